// ==== verilog/irq_vector_map.vh ====
// Constants for the interrupt vector mapper: vector numbers, offsets, priority codes.
// Assumes plain Verilog-2005 and inclusion by bare name.
`ifndef IRQ_VECTOR_MAP_VH
`define IRQ_VECTOR_MAP_VH

// ----------------------------------------
// Vector numbers
// ----------------------------------------
`define VEC_FLASH_ACC_ERR 7'h11
`define VEC_FLASH_CMD_DONE 7'h12
`define VEC_FLASH_BUF_EMPTY 7'h13
`define VEC_CONV_A_DONE 7'h3A
`define VEC_CONV_B_DONE 7'h3B
`define VEC_CONV_ZC_LIMIT 7'h3C
`define VEC_SOFT_LOW 7'h3F

// ----------------------------------------
// Fetch offsets from the vector base
// ----------------------------------------
`define OFF_FLASH_ACC_ERR 8'h22
`define OFF_FLASH_CMD_DONE 8'h24
`define OFF_FLASH_BUF_EMPTY 8'h26
`define OFF_CONV_A_DONE 8'h74
`define OFF_CONV_B_DONE 8'h76
`define OFF_CONV_ZC_LIMIT 8'h78
`define OFF_SOFT_LOW 8'h7E

// ----------------------------------------
// Priority field codes and ranks
// ----------------------------------------
`define PRIO_DISABLED 2'h0
`define PRIO_FIELD_W 2
`define PRIO_RESET 2'h0
// Rank 0 means nothing; 1 is the fixed level -1; 2..4 are levels 0..2.
`define RANK_NONE 3'h0
`define RANK_SOFT_LOW 3'h1

// ----------------------------------------
// Vector base
// ----------------------------------------
`define VBASE_W 21
`define VBASE_RESET 21'h000000
`define VEC_ADDR_W 19

`endif

// ==== verilog/irq_prio_pick.v ====
// Pure combinational arbiter over seven request lanes.
// Lane 0 has the lowest vector number; ranks come from the caller.
`timescale 1ns/1ps

module irq_prio_pick #(
    parameter LANES = 7
) (
    // Per-lane rank, three bits each
    input wire [3*LANES-1:0] rank_in,
    // Winner
    output reg [2:0] win_idx_out,
    output reg [2:0] win_rank_out
);
    integer i;

    always @*
    begin
        win_idx_out = 3'h0;
        win_rank_out = 3'h0;
        // Scan from the highest lane down so that on equal rank the lower lane wins.
        for (i = LANES - 1; i >= 0; i = i - 1)
        begin
            if (rank_in[3*i +: 3] != 3'h0 && rank_in[3*i +: 3] >= win_rank_out)
            begin
                win_idx_out = i[2:0];
                win_rank_out = rank_in[3*i +: 3];
            end
        end
    end
endmodule

// ==== verilog/interrupt_vector_map.v ====
// Interrupt vector mapper: turns peripheral requests into a vector number and
// fetch address for the core, with programmable priority per request except the low soft interrupt, which is fixed.
// Requests and control inputs are synchronous to clk_sys_in; the core takes
// the presented vector by pulsing ack_in while valid.
`timescale 1ns/1ps
`include "irq_vector_map.vh"

// What this block does
// - Flash access error goes to vector 17.
// - Flash done vector 18, buffers empty 19.
// - Converter A done maps to vector 58.
// - Converter B done maps to vector 59.
// - Zero-crossing or limit error share vector 60.
// - Low soft interrupt vector 63, fixed level -1.
// - Fetch offset is twice vector; 19-bit reach.
// - Reset vector base overlays chip reset addresses.
// - Priority code 00 disabled, then levels 0-2.
// - Enabled pending request wakes from wait/stop.
module interrupt_vector_map #(
    parameter LANES = 7
) (
    // Clock, reset, enable
    input wire clk_sys_in,
    input wire rst_in,
    input wire clk_en_in,
    // Peripheral requests (level, held until serviced)
    input wire flash_acc_err_in,
    input wire flash_cmd_done_in,
    input wire flash_buf_empty_in,
    input wire conv_a_done_in,
    input wire conv_b_done_in,
    input wire conv_zero_cross_in,
    input wire conv_limit_err_in,
    input wire soft_irq_low_prio_in,
    // Priority fields, two bits each, for the six programmable requests
    input wire [1:0] prio_flash_acc_err_in,
    input wire [1:0] prio_flash_cmd_done_in,
    input wire [1:0] prio_flash_buf_empty_in,
    input wire [1:0] prio_conv_a_in,
    input wire [1:0] prio_conv_b_in,
    input wire [1:0] prio_conv_zc_in,
    // Vector base and power mode
    input wire [`VBASE_W-1:0] vector_base_in,
    input wire low_power_in,
    // Core side
    input wire ack_in,
    output reg irq_valid_out,
    output reg [6:0] vector_num_out,
    output reg [7:0] vector_offset_out,
    output reg [`VEC_ADDR_W-1:0] vector_addr_out,
    output reg [2:0] irq_rank_out,
    // Wake request toward the system integration unit
    output reg wake_req_out
);

    // ----------------------------------------
    // Lane numbering
    // ----------------------------------------
    // Lanes follow vector number, so the arbiter's low-lane tie break is
    // the same as a low-vector tie break.
    localparam LANE_FLASH_ACC_ERR = 0;
    localparam LANE_FLASH_CMD_DONE = 1;
    localparam LANE_FLASH_BUF_EMPTY = 2;
    localparam LANE_CONV_A = 3;
    localparam LANE_CONV_B = 4;
    localparam LANE_CONV_ZC = 5;
    localparam LANE_SOFT_LOW = 6;

    // ----------------------------------------
    // Lane table
    // ----------------------------------------
    wire [LANES-1:0] req;
    wire [7*LANES-1:0] lane_vec;
    wire [8*LANES-1:0] lane_off;
    wire [2*LANES-1:0] lane_prio;
    reg [2*LANES-1:0] prio_held_q;
    wire [3*LANES-1:0] rank;

    assign req[LANE_FLASH_ACC_ERR] = flash_acc_err_in;
    assign req[LANE_FLASH_CMD_DONE] = flash_cmd_done_in;
    assign req[LANE_FLASH_BUF_EMPTY] = flash_buf_empty_in;
    assign req[LANE_CONV_A] = conv_a_done_in;
    assign req[LANE_CONV_B] = conv_b_done_in;
    assign req[LANE_CONV_ZC] = conv_zero_cross_in | conv_limit_err_in;
    assign req[LANE_SOFT_LOW] = soft_irq_low_prio_in;

    // Only documented vectors appear in this table, so no reserved number can be sent.
    assign lane_vec = {
        `VEC_SOFT_LOW,
        `VEC_CONV_ZC_LIMIT,
        `VEC_CONV_B_DONE,
        `VEC_CONV_A_DONE,
        `VEC_FLASH_BUF_EMPTY,
        `VEC_FLASH_CMD_DONE,
        `VEC_FLASH_ACC_ERR
    };

    // Two words per entry, so every offset here is twice its vector number.
    assign lane_off = {
        `OFF_SOFT_LOW,
        `OFF_CONV_ZC_LIMIT,
        `OFF_CONV_B_DONE,
        `OFF_CONV_A_DONE,
        `OFF_FLASH_BUF_EMPTY,
        `OFF_FLASH_CMD_DONE,
        `OFF_FLASH_ACC_ERR
    };

    // The soft interrupt has no field; its slot is never read.
    assign lane_prio = {
        `PRIO_DISABLED,
        prio_conv_zc_in,
        prio_conv_b_in,
        prio_conv_a_in,
        prio_flash_buf_empty_in,
        prio_flash_cmd_done_in,
        prio_flash_acc_err_in
    };

    // ----------------------------------------
    // Rank per lane
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1)
        begin : gen_rank
            if (g == LANES - 1)
            begin : gen_fixed
                // The low soft interrupt sits below every programmable level.
                assign rank[3*g +: 3] = req[g] ? `RANK_SOFT_LOW : `RANK_NONE;
            end
            else
            begin : gen_prog
                // Code 00 disables; 01..11 give levels 0..2 as ranks 2..4.
                // In low power the field held at entry is used, so only
                // requests enabled beforehand can wake the core.
                wire [1:0] fld;
                assign fld = low_power_in ? prio_held_q[2*g +: 2] : lane_prio[2*g +: 2];
                assign rank[3*g +: 3] = (req[g] && fld != `PRIO_DISABLED) ?
                    ({1'b0, fld} + 3'h1) : `RANK_NONE;
            end
        end
    endgenerate

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    wire [2:0] win_idx;
    wire [2:0] win_rank;

    irq_prio_pick #(
        .LANES(LANES)
    ) u_pick (
        .rank_in(rank),
        .win_idx_out(win_idx),
        .win_rank_out(win_rank)
    );

    wire [6:0] win_vec;
    wire [7:0] win_off;
    wire [`VEC_ADDR_W-1:0] win_addr;
    wire win_any;
    wire take;

    assign win_vec = lane_vec[7*win_idx +: 7];
    assign win_off = lane_off[8*win_idx +: 8];
    // The entry reaches only 19 bits, so carries out of the sum are dropped.
    // A zero base puts entry 0 on the reset address.
    assign win_addr = vector_base_in[`VEC_ADDR_W-1:0] + {11'h000, win_off};
    assign win_any = win_rank != `RANK_NONE;
    // A presented vector may only be replaced once the core has taken it.
    assign take = !irq_valid_out || ack_in;

    // ----------------------------------------
    // Enables held across low power
    // ----------------------------------------
    // The fields are sampled while running and frozen in wait or stop, so a
    // request enabled only after entry cannot wake the core.
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prio_held_q <= {LANES{`PRIO_RESET}};
        end
        else if (clk_en_in && !low_power_in)
        begin
            prio_held_q <= lane_prio;
        end
    end

    // ----------------------------------------
    // Wake request
    // ----------------------------------------
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wake_req_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            wake_req_out <= low_power_in && win_any;
        end
    end

    // ----------------------------------------
    // Presentation to the core
    // ----------------------------------------
    always @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_valid_out <= 1'b0;
            vector_num_out <= 7'h00;
            vector_offset_out <= 8'h00;
            vector_addr_out <= {`VEC_ADDR_W{1'b0}};
            irq_rank_out <= `RANK_NONE;
        end
        else if (clk_en_in && take)
        begin
            // The slot stays empty for one cycle after a take, so the core sees
            // a clean edge before the next vector.
            irq_valid_out <= win_any && !(irq_valid_out && ack_in);
            vector_num_out <= win_vec;
            vector_offset_out <= win_off;
            vector_addr_out <= win_addr;
            irq_rank_out <= win_rank;
        end
    end

endmodule

// ==== test/core_model.sv ====
// Processor core stand-in: takes each presented vector after a stall.
// Assumes valid_in comes from the mapper's registered presentation.
`timescale 1ns/1ps
module core_model (
    input wire clk_in,
    input wire rst_in,
    input wire valid_in,
    input wire [1:0] stall_in,
    output reg ack_out
);
reg [2:0] cnt_q;
// The wait is at least three cycles so the bench can drop requests first.
always @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        ack_out <= 1'b0;
        cnt_q <= 3'h0;
    end
    else if (ack_out)
    begin
        ack_out <= 1'b0;
        cnt_q <= 3'h0;
    end
    else if (valid_in)
    begin
        if (cnt_q == {1'b0, stall_in} + 3'h2)
            ack_out <= 1'b1;
        else
            cnt_q <= cnt_q + 3'h1;
    end
end
endmodule

// ==== test/interrupt_vector_map_properties.sv ====
// Checker for the vector mapper, bound to its ports.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module ivm_props (
    input wire clk_sys_in,
    input wire rst_in,
    input wire clk_en_in,
    input wire ack_in,
    input wire low_power_in,
    input wire soft_irq_low_prio_in,
    input wire irq_valid_out,
    input wire [6:0] vector_num_out,
    input wire [7:0] vector_offset_out,
    input wire [2:0] irq_rank_out,
    input wire wake_req_out
);
default clocking @(posedge clk_sys_in); endclocking
default disable iff (rst_in);
property p_off; irq_valid_out |-> vector_offset_out == {vector_num_out, 1'b0}; endproperty
a_off: assert property (p_off) else $error("bad offset");
property p_vec; irq_valid_out |-> vector_num_out inside {17, 18, 19, 58, 59, 60, 63}; endproperty
a_vec: assert property (p_vec) else $error("bad vector");
property p_srk; irq_valid_out && vector_num_out == 63 |-> irq_rank_out == 3'h1; endproperty
a_srk: assert property (p_srk) else $error("bad soft rank");
property p_prk; irq_valid_out && vector_num_out != 63 |-> irq_rank_out >= 3'h2; endproperty
a_prk: assert property (p_prk) else $error("bad rank");
property p_hold; irq_valid_out && !ack_in |=> irq_valid_out && $stable(vector_num_out); endproperty
a_hold: assert property (p_hold) else $error("vector not held");
property p_drop; irq_valid_out && ack_in && clk_en_in |=> !irq_valid_out; endproperty
a_drop: assert property (p_drop) else $error("no drop after ack");
property p_wake; $past(clk_en_in) && wake_req_out |-> $past(low_power_in); endproperty
a_wake: assert property (p_wake) else $error("wake outside low power");
property p_soft; !irq_valid_out && soft_irq_low_prio_in && clk_en_in |=> irq_valid_out; endproperty
a_soft: assert property (p_soft) else $error("soft request lost");
endmodule
bind interrupt_vector_map ivm_props ivm_props_i (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .ack_in(ack_in),
    .low_power_in(low_power_in),
    .soft_irq_low_prio_in(soft_irq_low_prio_in),
    .irq_valid_out(irq_valid_out),
    .vector_num_out(vector_num_out),
    .vector_offset_out(vector_offset_out),
    .irq_rank_out(irq_rank_out),
    .wake_req_out(wake_req_out)
);

// ==== test/interrupt_vector_map_bench.sv ====
// Bench: random requests and priorities checked against an integer model.
// Assumes the core model and checker files are compiled first.
`timescale 1ns/1ps
module interrupt_vector_map_bench;
reg clk_sys_in = 0;
reg rst_in = 1;
reg [7:0] rq = 0;
reg [11:0] pr = 0;
reg [20:0] base = 0;
reg lp = 0;
reg en = 1;
reg [11:0] ph = 0;
reg [11:0] pe = 0;
reg [1:0] stall = 0;
wire ack, vld, wake;
wire [6:0] num;
wire [7:0] off;
wire [18:0] addr;
wire [2:0] rank;
integer miscompares = 0, checked = 0, cyc = 0, i, k, q, er, ev, rk, ew;
interrupt_vector_map interrupt_vector_map_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .clk_en_in(en), .flash_acc_err_in(rq[0]), .flash_cmd_done_in(rq[1]),
    .flash_buf_empty_in(rq[2]), .conv_a_done_in(rq[3]), .conv_b_done_in(rq[4]),
    .conv_zero_cross_in(rq[5]), .conv_limit_err_in(rq[6]), .soft_irq_low_prio_in(rq[7]),
    .prio_flash_acc_err_in(pr[1:0]), .prio_flash_cmd_done_in(pr[3:2]),
    .prio_flash_buf_empty_in(pr[5:4]), .prio_conv_a_in(pr[7:6]), .prio_conv_b_in(pr[9:8]),
    .prio_conv_zc_in(pr[11:10]), .vector_base_in(base), .low_power_in(lp), .ack_in(ack),
    .irq_valid_out(vld), .vector_num_out(num), .vector_offset_out(off),
    .vector_addr_out(addr), .irq_rank_out(rank), .wake_req_out(wake));
core_model core_model_i (.clk_in(clk_sys_in), .rst_in(rst_in), .valid_in(vld),
    .stall_in(stall), .ack_out(ack));
task cmp(input [31:0] g, input [31:0] e);
begin
    checked = checked + 1;
    if (g !== e)
    begin
        miscompares = miscompares + 1;
        $display("ERROR %0t got %h exp %h", $time, g, e);
    end
end
endtask
task final_report;
begin
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
end
endtask
initial
begin
    forever #20 clk_sys_in = ~clk_sys_in;
end
always @(posedge clk_sys_in)
begin
    cyc <= cyc + 1;
    if (cyc > 20000)
    begin
        miscompares = miscompares + 1;
        final_report;
    end
end
initial
begin
    void'($urandom(32'h9994));
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 0;
    for (i = 0; i < 80; i = i + 1)
    begin
        @(posedge clk_sys_in);
        pr <= $urandom;
        stall <= $urandom;
        base <= (i % 4) ? $urandom : 0;
        @(posedge clk_sys_in);
        // The fields stand at this edge; fresh fields arriving together with
        // low power must enable nothing until low power ends.
        ph = pr;
        rq <= $urandom;
        lp <= $urandom;
        pr <= $urandom;
        repeat (2) @(posedge clk_sys_in);
        #1;
        pe = lp ? ph : pr;
        er = 0;
        ev = 0;
        // Strict compare keeps the lowest vector among equal ranks.
        for (k = 0; k < 7; k = k + 1)
        begin
            q = k == 6 ? rq[7] : k == 5 ? rq[5] | rq[6] : rq[k];
            rk = k == 6 ? q : (q && pe[2*k+:2] != 0) ? pe[2*k+:2] + 1 : 0;
            if (rk > er)
            begin
                er = rk;
                ev = k < 3 ? 17 + k : k < 6 ? 55 + k : 63;
            end
        end
        ew = lp && er != 0;
        cmp(vld, er != 0);
        cmp(wake, ew);
        if (er != 0)
        begin
            cmp(num, ev);
            cmp(off, 2 * ev);
            cmp(addr, (base + 2 * ev) & 32'h7FFFF);
            cmp(rank, er);
        end
        // Two edges with the enable low: nothing may move, not even on an ack.
        @(posedge clk_sys_in);
        rq <= 0;
        lp <= 0;
        en <= 0;
        repeat (2) @(posedge clk_sys_in);
        en <= 1;
        #1;
        cmp(vld, er != 0);
        cmp(wake, ew);
        if (er != 0)
            cmp(num, ev);
        for (k = 0; k < 20 && vld; k = k + 1)
        begin
            @(posedge clk_sys_in);
            #1;
        end
        repeat (2) @(posedge clk_sys_in);
        #1;
        cmp(vld, 0);
    end
    final_report;
end
endmodule
